// [seep_host_bfm.sv]
// two-wire host model: drives the serial clock and pulls the data line
`timescale 1ns/1ps
module seep_host_bfm (
    // system clock for pacing
    input  wire logic CLK,
    // resolved data line
    input  wire logic SDA_LINE,
    // host side of the bus
    output logic      SCL,
    output logic      SDA_PULL
);
    ////////////////////////////////////////////////////////////////////////////////
    // idle bus: clock stands high, data released to the pull-up
    initial begin
        SCL      = 1'h1;
        SDA_PULL = 1'h0;
    end
    // hold the bus for n system clocks, change just after the edge
    task automatic step(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    // start: data falls while clock high, then clock low
    task automatic start_cond();
        SDA_PULL = 1'h1;
        step(8);
        SCL = 1'h0;
        step(8);
    endtask
    // one bit from the device: release data with clock low, sample with clock high
    task automatic read_bit(output logic b);
        SDA_PULL = 1'h0;
        step(8);
        SCL = 1'h1;
        step(8);
        b = SDA_LINE;
        SCL = 1'h0;
        step(8);
    endtask
    // stop: data low with clock low, clock high, then data rises
    task automatic stop_cond();
        SDA_PULL = 1'h1;
        step(8);
        SCL = 1'h1;
        step(8);
        SDA_PULL = 1'h0;
        step(8);
    endtask
endmodule

// [seep_pkg.sv]
// constants and types shared by the serial eeprom select and protect block
package seep_pkg;
    // device type identifiers in the upper nibble of the address byte
    localparam logic [3:0] SEEP_TYPE_ARRAY  = 4'hA;
    localparam logic [3:0] SEEP_TYPE_SECCFG = 4'hB;
    // address byte field positions
    localparam int SEEP_DIR_BIT   = 0;
    localparam int SEEP_HW_LSB    = 1;
    localparam int SEEP_HW_MSB    = 3;
    localparam int SEEP_TYPE_LSB  = 4;
    // array organisation: 512 pages of 64 bytes
    localparam int SEEP_PAGE_COUNT = 512;
    localparam int SEEP_PAGE_BYTES = 64;
    localparam int SEEP_OFS_W      = $clog2(SEEP_PAGE_BYTES);
    localparam int SEEP_PAGE_W     = $clog2(SEEP_PAGE_COUNT);
    localparam int SEEP_ADDR_W     = SEEP_OFS_W + SEEP_PAGE_W;
    // configuration register: position of enhanced protection select
    localparam int SEEP_CFG_ESWP_BIT = 0;
    localparam logic [7:0] SEEP_CFG_RESET = 8'h00;
    // factory serial number, value arbitrary
    localparam logic [127:0] SEEP_SERIAL_RESET = 128'h5A5A_0F0F_3C3C_9696_1234_5678_9ABC_DEF0;
    // reset levels of the synchronised pins: scl, sda idle high
    localparam logic [6:0] SEEP_PIN_RESET = 7'h03;
    // pin vector positions
    localparam int SEEP_PIN_SCL = 0;
    localparam int SEEP_PIN_SDA = 1;
    localparam int SEEP_PIN_A0  = 2;
    localparam int SEEP_PIN_WP  = 5;
    localparam int SEEP_PIN_POR = 6;
    // target of a write
    typedef enum logic [1:0] {
        SEEP_REG_ARRAY  = 2'h0,
        SEEP_REG_SERIAL = 2'h1,
        SEEP_REG_IDPAGE = 2'h2,
        SEEP_REG_CONFIG = 2'h3
    } seep_region_type;
    // device state, gray along reset, standby, selected
    typedef enum logic [1:0] {
        SEEP_ST_RESET    = 2'h0,
        SEEP_ST_STANDBY  = 2'h1,
        SEEP_ST_SELECTED = 2'h3
    } seep_state_type;
endpackage

// [seep_sync.sv]
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
module seep_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input  wire logic CLK,
    input  wire logic SRST,
    // pin in, filtered level out
    input  wire logic PIN,
    output logic      LEVEL
);
    logic s1_q;     // first stage, read by s2 only
    logic s2_q;     // second stage
    logic s3_q;     // third stage
    logic level_q;  // accepted level

    // shift chain
    always_ff @(posedge CLK) begin
        if (SRST) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
        end else begin
            s1_q <= PIN;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // change counts once stages two and three agree
    always_ff @(posedge CLK) begin
        if (SRST) begin
            level_q <= RST_VAL;
        end else if (s2_q == s3_q) begin
            level_q <= s3_q;
        end
    end

    assign LEVEL = level_q;
endmodule

// [seep_tb_top.sv]
// self-checking bench for the select and write protection block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module seep_tb_top;
    import seep_pkg::*;
    ////////////////////////////////////////////////////////////////////////////////
    // stimulus, all given a value at time zero
    logic clk = 1'h0, srst = 1'h1, por = 1'h0, wp = 1'h0, av = 1'h0, pull = 1'h0;
    logic wr = 1'h0, lk_cfg = 1'h0, lk_id = 1'h0;
    logic [2:0]             sel   = 3'h5;
    logic [7:0]             ab    = 8'h00;
    logic [7:0]             wdat  = 8'h00;
    logic [SEEP_ADDR_W-1:0] waddr = '0;
    seep_region_type        wreg  = SEEP_REG_ARRAY;
    // design outputs
    logic ready, selected, start_det, stop_det, ack, nak, xrd, seccfg;
    logic wok, wblk, sda_o, sda_oe_n, cfg_locked, id_locked;
    logic [SEEP_ADDR_W-1:0] next_addr;
    logic [7:0]             cfg_value;
    logic [127:0]           serial;
    // bus wires: open-drain with pull-up
    logic scl, host_pull, b;
    wire  sda_line = (host_pull || !sda_oe_n) ? 1'h0 : 1'h1;
    // bookkeeping
    int fail_count = 0, n_compared = 0, n_start = 0, n_stop = 0, cycles = 0;
    // host keeps power_up_wait, 100 us at the 40 ns clock, before its first command
    localparam int power_up_wait_cyc = 2500;
    ////////////////////////////////////////////////////////////////////////////////
    always #20 clk = ~clk;
    seep_host_bfm host (.CLK(clk), .SDA_LINE(sda_line), .SCL(scl), .SDA_PULL(host_pull));
    seep_top u_dut (
        .CLK(clk), .SRST(srst), .POWER_ON_THRESHOLD(por),
        .ADDR_SELECT_BIT_ZERO(sel[0]), .ADDR_SELECT_BIT_ONE(sel[1]),
        .ADDR_SELECT_BIT_TWO(sel[2]), .WP(wp), .SCL_I(scl), .SDA_I(sda_line),
        .SDA_O(sda_o), .SDA_OE_N(sda_oe_n), .ADDR_VALID(av), .ADDR_BYTE(ab),
        .SDA_PULL_LOW(pull), .WR_REQ(wr), .WR_REGION(wreg), .WR_ADDR(waddr),
        .WR_DATA(wdat), .LOCK_CFG_REQ(lk_cfg), .LOCK_ID_REQ(lk_id), .READY(ready),
        .SELECTED(selected), .START_DET(start_det), .STOP_DET(stop_det),
        .ADDR_ACK(ack), .ADDR_NAK(nak), .XFER_READ(xrd), .SEL_SECCFG(seccfg),
        .WR_OK(wok), .WR_BLOCK(wblk), .WR_NEXT_ADDR(next_addr), .CFG_VALUE(cfg_value),
        .CFG_LOCKED(cfg_locked), .ID_LOCKED(id_locked), .SERIAL_NUM(serial));
    ////////////////////////////////////////////////////////////////////////////////
    // condition counters and hang guard
    always @(posedge clk) begin
        cycles++;
        if (start_det === 1'h1) n_start++;
        if (stop_det === 1'h1) n_stop++;
        if (cycles == 5000) begin
            fail_count++;
            print_verdict();
        end
    end
    // counts, verdict, end of run
    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // address byte pulse, answer one cycle on, then one idle cycle
    task automatic do_addr(input logic [7:0] v, input logic e_ack, input logic e_nak);
        av = 1'h1;
        ab = v;
        tick();
        `CHK("addr_ack", e_ack, ack)
        `CHK("addr_nak", e_nak, nak)
        av = 1'h0;
        tick();
    endtask
    // write request pulse, permit or block one cycle on
    task automatic do_write(input seep_region_type r, input logic [14:0] a,
                            input logic e_ok, input logic e_blk);
        wr = 1'h1;
        wreg = r;
        waddr = a;
        wdat = a[7:0];
        tick();
        `CHK("wr_ok", e_ok, wok)
        `CHK("wr_block", e_blk, wblk)
        wr = 1'h0;
        tick();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // power-on hold-off: nothing answered below threshold
    task automatic t_por();
        tick(8);
        `CHK("ready", 1'h0, ready)
        do_addr({SEEP_TYPE_ARRAY, sel, 1'h0}, 1'h0, 1'h0);
        do_write(SEEP_REG_ARRAY, 15'h0000, 1'h0, 1'h0);
        por = 1'h1;
        for (int i = 0; i < 20 && ready !== 1'h1; i++) begin
            tick();
        end
        `CHK("ready", 1'h1, ready)
        tick(power_up_wait_cyc);
    endtask
    // address compare, direction bit, mismatches
    task automatic t_select();
        for (int d = 0; d < 2; d++) begin
            do_addr({SEEP_TYPE_ARRAY, sel, d[0]}, 1'h1, 1'h0);
            `CHK("xfer_read", d[0], xrd)
        end
        do_addr({SEEP_TYPE_SECCFG, sel, 1'h1}, 1'h1, 1'h0);
        `CHK("seccfg", 1'h1, seccfg)
        for (int i = 0; i < 8; i++) begin
            if (i[2:0] != sel) begin
                do_addr({SEEP_TYPE_ARRAY, i[2:0], 1'h0}, 1'h0, 1'h1);
                `CHK("selected", 1'h0, selected)
            end
        end
        do_addr({4'h5, sel, 1'h0}, 1'h0, 1'h1);
        sel = 3'h2;
        tick(8);
        do_addr({SEEP_TYPE_ARRAY, 3'h2, 1'h0}, 1'h1, 1'h0);
        `CHK("selected", 1'h1, selected)
        `CHK("seccfg", 1'h0, seccfg)
    endtask
    // write gating by pin, enhanced mode, locks, page wrap
    task automatic t_write();
        do_write(SEEP_REG_ARRAY, 15'h003F, 1'h1, 1'h0);
        `CHK("next_addr", 15'h0000, next_addr)
        do_write(SEEP_REG_ARRAY, 15'h7FC1, 1'h1, 1'h0);
        `CHK("next_addr", 15'h7FC2, next_addr)
        do_write(SEEP_REG_IDPAGE, 15'h0001, 1'h1, 1'h0);
        do_write(SEEP_REG_SERIAL, 15'h0000, 1'h0, 1'h1);
        `CHK("serial", SEEP_SERIAL_RESET, serial)
        wp = 1'h1;
        tick(8);
        do_write(SEEP_REG_ARRAY, 15'h0100, 1'h0, 1'h1);
        do_write(SEEP_REG_IDPAGE, 15'h0002, 1'h0, 1'h1);
        do_write(SEEP_REG_CONFIG, 15'h0001, 1'h1, 1'h0);
        `CHK("cfg_value", 8'h01, cfg_value)
        do_write(SEEP_REG_ARRAY, 15'h0100, 1'h1, 1'h0);
        lk_id = 1'h1;
        tick();
        `CHK("id_locked", 1'h1, id_locked)
        lk_id = 1'h0;
        do_write(SEEP_REG_IDPAGE, 15'h0003, 1'h0, 1'h1);
        lk_cfg = 1'h1;
        tick();
        `CHK("cfg_locked", 1'h1, cfg_locked)
        lk_cfg = 1'h0;
        do_write(SEEP_REG_CONFIG, 15'h0000, 1'h0, 1'h1);
        `CHK("cfg_value", 8'h01, cfg_value)
    endtask
    // start, device-driven zero bit, stop
    task automatic t_bus();
        host.start_cond();
        pull = 1'h1;
        tick(2);
        `CHK("sda_oe_n", 1'h0, sda_oe_n)
        host.read_bit(b);
        `CHK("sda_bit", 1'h0, b)
        `CHK("sda_o", 1'h0, sda_o)
        pull = 1'h0;
        tick(2);
        `CHK("sda_line", 1'h1, sda_line)
        host.stop_cond();
        `CHK("starts", 1, n_start)
        `CHK("stops", 1, n_stop)
        // supply drop: back into power-on reset, traffic ignored again
        por = 1'h0;
        tick(6);
        `CHK("ready", 1'h0, ready)
        do_addr({SEEP_TYPE_ARRAY, sel, 1'h0}, 1'h0, 1'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        tick(3);
        srst = 1'h0;
        t_por();
        t_select();
        t_write();
        t_bus();
        print_verdict();
    end
endmodule

// [seep_top.sv]
// select, power-on hold-off and write protection of a serial eeprom
`timescale 1ns/1ps
// Functional notes
// - ignore all commands until supply passes threshold
// - selected only when all three select pins match
// - write-protect high blocks array and security writes
// - enhanced protection mode disregards write-protect pin
// - data change with clock high is start/stop
// - data line only pulled low or released
// - array is 512 pages of 64 bytes
// - configuration register selects protection behaviour
// - locked configuration register refuses all writes
// - factory serial number readable, never writable
// - id page writable until locked, then never
// - address mismatch gives no response, back to standby
// - address lsb one reads, zero writes
module seep_top
    import seep_pkg::*;
(
    // clock and reset
    input  wire logic                             CLK,
    input  wire logic                             SRST,
    // supply monitor and static pins
    input  wire logic                             POWER_ON_THRESHOLD,
    input  wire logic                             ADDR_SELECT_BIT_ZERO,
    input  wire logic                             ADDR_SELECT_BIT_ONE,
    input  wire logic                             ADDR_SELECT_BIT_TWO,
    input  wire logic                             WP,
    // two-wire bus pins
    input  wire logic                             SCL_I,
    input  wire logic                             SDA_I,
    output logic                                  SDA_O,
    output logic                                  SDA_OE_N,
    // bus engine: received address byte
    input  wire logic                             ADDR_VALID,
    input  wire logic [7:0]                       ADDR_BYTE,
    // bus engine: pull data line low request
    input  wire logic                             SDA_PULL_LOW,
    // bus engine: write request
    input  wire logic                             WR_REQ,
    input  wire seep_pkg::seep_region_type        WR_REGION,
    input  wire logic [seep_pkg::SEEP_ADDR_W-1:0] WR_ADDR,
    input  wire logic [7:0]                       WR_DATA,
    // bus engine: lock requests
    input  wire logic                             LOCK_CFG_REQ,
    input  wire logic                             LOCK_ID_REQ,
    // status
    output logic                                  READY,
    output logic                                  SELECTED,
    output logic                                  START_DET,
    output logic                                  STOP_DET,
    // address answer
    output logic                                  ADDR_ACK,
    output logic                                  ADDR_NAK,
    output logic                                  XFER_READ,
    output logic                                  SEL_SECCFG,
    // write answer
    output logic                                  WR_OK,
    output logic                                  WR_BLOCK,
    output logic [seep_pkg::SEEP_ADDR_W-1:0]      WR_NEXT_ADDR,
    // register contents
    output logic [7:0]                            CFG_VALUE,
    output logic                                  CFG_LOCKED,
    output logic                                  ID_LOCKED,
    output logic [127:0]                          SERIAL_NUM
);
    import seep_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    ////////////////////////////////////////////////////////////////////////
    logic [6:0] pin_raw;   // raw pin vector
    logic [6:0] pin_f;     // filtered pin levels

    assign pin_raw = {POWER_ON_THRESHOLD, WP, ADDR_SELECT_BIT_TWO,
                      ADDR_SELECT_BIT_ONE, ADDR_SELECT_BIT_ZERO, SDA_I, SCL_I};

    // one synchroniser per pin
    for (genvar i = 0; i < 7; i++) begin : g_sync
        seep_sync #(
            .RST_VAL (SEEP_PIN_RESET[i])
        ) u_sync (
            .CLK   (CLK),
            .SRST  (SRST),
            .PIN   (pin_raw[i]),
            .LEVEL (pin_f[i])
        );
    end

    logic       scl_f;     // filtered clock line
    logic       sda_f;     // filtered data line
    logic [2:0] sel_pins;  // filtered select pins, valid levels assumed
    logic       wp_f;      // filtered write-protect
    logic       por_f;     // supply above threshold

    assign scl_f    = pin_f[SEEP_PIN_SCL];
    assign sda_f    = pin_f[SEEP_PIN_SDA];
    assign sel_pins = pin_f[SEEP_PIN_A0+2:SEEP_PIN_A0];
    assign wp_f     = pin_f[SEEP_PIN_WP];
    assign por_f    = pin_f[SEEP_PIN_POR];

    ////////////////////////////////////////////////////////////////////////
    // start and stop detection
    ////////////////////////////////////////////////////////////////////////
    logic scl_prev_q;  // clock line last cycle
    logic sda_prev_q;  // data line last cycle
    logic start_q;     // start seen
    logic stop_q;      // stop seen
    logic start_w;     // falling data, clock high
    logic stop_w;      // rising data, clock high

    assign start_w = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
    assign stop_w  = scl_f & scl_prev_q & ~sda_prev_q & sda_f;

    // edge history and condition flags
    always_ff @(posedge CLK) begin
        if (SRST) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            start_q    <= 1'b0;
            stop_q     <= 1'b0;
        end else begin
            scl_prev_q <= scl_f;
            sda_prev_q <= sda_f;
            start_q    <= start_w & por_f;
            stop_q     <= stop_w & por_f;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power-on hold-off and select state
    ////////////////////////////////////////////////////////////////////////
    seep_state_type state_q;  // current state
    seep_state_type state_d;  // next state
    logic           ready_w;  // device accepts traffic
    logic           type_ok;  // known device type
    logic           hw_ok;    // select pins agree
    logic           match_w;  // address byte accepted

    assign ready_w = (state_q != SEEP_ST_RESET);
    assign type_ok = (ADDR_BYTE[7:SEEP_TYPE_LSB] == SEEP_TYPE_ARRAY) |
                     (ADDR_BYTE[7:SEEP_TYPE_LSB] == SEEP_TYPE_SECCFG);
    assign hw_ok   = (ADDR_BYTE[SEEP_HW_MSB:SEEP_HW_LSB] == sel_pins);
    assign match_w = ready_w & ADDR_VALID & type_ok & hw_ok;

    // state transitions
    always_comb begin
        state_d = state_q;
        case (state_q)
            SEEP_ST_RESET: begin
                // leave reset once the supply is good
                if (por_f) state_d = SEEP_ST_STANDBY;
            end
            SEEP_ST_STANDBY:  if (match_w) state_d = SEEP_ST_SELECTED;
            SEEP_ST_SELECTED: begin
                // stop or a foreign address byte ends the transfer
                if (stop_w | (ADDR_VALID & ~match_w)) state_d = SEEP_ST_STANDBY;
            end
            default: state_d = SEEP_ST_RESET;
        endcase
        // supply drop forces reset
        if (!por_f) state_d = SEEP_ST_RESET;
    end

    // state register
    always_ff @(posedge CLK) begin
        if (SRST) state_q <= SEEP_ST_RESET;
        else      state_q <= state_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // address answer
    ////////////////////////////////////////////////////////////////////////
    logic ready_q;   // registered ready
    logic sel_q;     // registered selected
    logic ack_q;     // address matched
    logic nak_q;     // address ignored
    logic read_q;    // transfer direction
    logic seccfg_q;  // security or config access

    // answer one cycle after the byte
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ready_q  <= 1'b0;
            sel_q    <= 1'b0;
            ack_q    <= 1'b0;
            nak_q    <= 1'b0;
            read_q   <= 1'b0;
            seccfg_q <= 1'b0;
        end else begin
            ready_q <= (state_d != SEEP_ST_RESET);
            sel_q   <= (state_d == SEEP_ST_SELECTED);
            ack_q   <= match_w;
            nak_q   <= ready_w & ADDR_VALID & ~match_w;
            if (match_w) begin
                read_q   <= ADDR_BYTE[SEEP_DIR_BIT];
                seccfg_q <= (ADDR_BYTE[7:SEEP_TYPE_LSB] == SEEP_TYPE_SECCFG);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // open-drain data line
    ////////////////////////////////////////////////////////////////////////
    logic oe_n_q;  // low while pulling the line low

    // only pull low when ready, never drive high
    always_ff @(posedge CLK) begin
        if (SRST) oe_n_q <= 1'b1;
        else      oe_n_q <= ~(SDA_PULL_LOW & ready_w);
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration, locks and write gate
    ////////////////////////////////////////////////////////////////////////
    logic [7:0]             cfg_q;       // configuration contents
    logic                   cfg_lock_q;  // configuration locked
    logic                   id_lock_q;   // id page locked
    logic                   eswp_w;      // enhanced protection selected
    logic                   permit_w;    // write allowed
    logic [SEEP_ADDR_W-1:0] next_w;      // next address in page
    logic                   wr_ok_q;     // write granted
    logic                   wr_blk_q;    // write refused
    logic [SEEP_ADDR_W-1:0] next_q;      // registered next address
    logic [127:0]           serial_q;    // serial number copy

    assign eswp_w = cfg_q[SEEP_CFG_ESWP_BIT];

    seep_wr_gate u_gate (
        .READY      (ready_w),
        .REGION     (WR_REGION),
        .ADDR       (WR_ADDR),
        .WP_LEVEL   (wp_f),
        .ESWP       (eswp_w),
        .CFG_LOCKED (cfg_lock_q),
        .ID_LOCKED  (id_lock_q),
        .PERMIT     (permit_w),
        .NEXT_ADDR  (next_w)
    );

    // write answer and config update
    always_ff @(posedge CLK) begin
        if (SRST) begin
            wr_ok_q  <= 1'b0;
            wr_blk_q <= 1'b0;
            next_q   <= '0;
            cfg_q    <= SEEP_CFG_RESET;
        end else begin
            wr_ok_q  <= WR_REQ & permit_w;
            wr_blk_q <= WR_REQ & ~permit_w & ready_w;
            if (WR_REQ & permit_w) next_q <= next_w;
            if (WR_REQ & permit_w & (WR_REGION == SEEP_REG_CONFIG)) begin
                cfg_q <= WR_DATA;
            end
        end
    end

    // lock flags only ever set
    always_ff @(posedge CLK) begin
        if (SRST) begin
            cfg_lock_q <= 1'b0;
            id_lock_q  <= 1'b0;
        end else begin
            if (LOCK_CFG_REQ & ready_w) cfg_lock_q <= 1'b1;
            if (LOCK_ID_REQ & ready_w)  id_lock_q  <= 1'b1;
        end
    end

    // serial number held constant, no write path reaches it
    always_ff @(posedge CLK) serial_q <= SEEP_SERIAL_RESET;

    ////////////////////////////////////////////////////////////////////////
    // outputs
    ////////////////////////////////////////////////////////////////////////
    assign SDA_O        = 1'b0;
    assign SDA_OE_N     = oe_n_q;
    assign READY        = ready_q;
    assign SELECTED     = sel_q;
    assign START_DET    = start_q;
    assign STOP_DET     = stop_q;
    assign ADDR_ACK     = ack_q;
    assign ADDR_NAK     = nak_q;
    assign XFER_READ    = read_q;
    assign SEL_SECCFG   = seccfg_q;
    assign WR_OK        = wr_ok_q;
    assign WR_BLOCK     = wr_blk_q;
    assign WR_NEXT_ADDR = next_q;
    assign CFG_VALUE    = cfg_q;
    assign CFG_LOCKED   = cfg_lock_q;
    assign ID_LOCKED    = id_lock_q;
    assign SERIAL_NUM   = serial_q;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    a_hold_off_reset: assert property (ack_q |-> $past(ready_w) && $past(ADDR_VALID))
        else $error("address answered while in reset");
    a_select_pins: assert property (ack_q |-> $past(ADDR_BYTE[3:1]) == $past(sel_pins))
        else $error("selected with select pins mismatched");
    a_nak_standby: assert property (nak_q |-> state_q != SEEP_ST_SELECTED)
        else $error("mismatch did not return to standby");
    a_dir_bit: assert property (ack_q |-> read_q == $past(ADDR_BYTE[0]))
        else $error("direction bit not taken");
    a_wp_blocks: assert property (
        WR_REQ && ready_w && wp_f && !eswp_w && WR_REGION == SEEP_REG_ARRAY
        |=> wr_blk_q && !wr_ok_q
    ) else $error("array write passed write-protect");
    a_eswp_ignores: assert property (
        WR_REQ && ready_w && eswp_w && WR_REGION == SEEP_REG_ARRAY |=> wr_ok_q
    ) else $error("enhanced mode still obeyed pin");
    a_sda_open: assert property (!oe_n_q |-> SDA_O == 1'b0 && $past(SDA_PULL_LOW))
        else $error("data line driven without request");
    a_page_wrap: assert property (
        wr_ok_q |-> next_q[SEEP_ADDR_W-1:SEEP_OFS_W] == $past(WR_ADDR[SEEP_ADDR_W-1:SEEP_OFS_W])
    ) else $error("address left its page");
    a_cfg_frozen: assert property (cfg_lock_q |=> $stable(cfg_q) && cfg_lock_q)
        else $error("locked configuration changed");
    a_serial_fixed: assert property (
        serial_q == SEEP_SERIAL_RESET && !(wr_ok_q && $past(WR_REGION) == SEEP_REG_SERIAL)
    ) else $error("serial number writable");
    a_id_locked: assert property (
        id_lock_q && WR_REQ && WR_REGION == SEEP_REG_IDPAGE |=> !wr_ok_q
    ) else $error("locked id page written");
    a_start_clk_high: assert property (
        start_q |-> $past(scl_f) && $past(sda_prev_q) && !$past(sda_f)
    ) else $error("start without clock high");

    c_addr_ack: cover property (ADDR_VALID ##1 ack_q);
    c_wr_block: cover property (wr_blk_q);
    c_cfg_lock: cover property (!cfg_lock_q ##1 cfg_lock_q);
    c_start_stop: cover property (start_q ##[1:200] stop_q);
endmodule

// [seep_wr_gate.sv]
// write permission and in-page address advance
`timescale 1ns/1ps
module seep_wr_gate
    import seep_pkg::*;
(
    // request
    input  wire logic                   READY,
    input  wire seep_region_type        REGION,
    input  wire logic [SEEP_ADDR_W-1:0] ADDR,
    // protection state
    input  wire logic                   WP_LEVEL,
    input  wire logic                   ESWP,
    input  wire logic                   CFG_LOCKED,
    input  wire logic                   ID_LOCKED,
    // decision
    output logic                        PERMIT,
    output logic [SEEP_ADDR_W-1:0]      NEXT_ADDR
);
    logic                  hw_ok;    // pin allows, or pin disregarded
    logic [SEEP_OFS_W-1:0] ofs_inc;  // offset plus one, wraps in page

    // enhanced mode disregards the pin
    assign hw_ok = ESWP | ~WP_LEVEL;

    // permission per target
    always_comb begin
        PERMIT = 1'b0;
        case (REGION)
            SEEP_REG_ARRAY:  PERMIT = READY & hw_ok;
            SEEP_REG_SERIAL: PERMIT = 1'b0;
            SEEP_REG_IDPAGE: PERMIT = READY & hw_ok & ~ID_LOCKED;
            SEEP_REG_CONFIG: PERMIT = READY & ~CFG_LOCKED;
            default:         PERMIT = 1'b0;
        endcase
    end

    // roll over inside the page, never into the next
    assign ofs_inc   = ADDR[SEEP_OFS_W-1:0] + SEEP_OFS_W'(1);
    assign NEXT_ADDR = {ADDR[SEEP_ADDR_W-1:SEEP_OFS_W], ofs_inc};
endmodule
